// file: src/wrp_pkg.sv
// Package of constants and types shared by the waveform RAM player and its FIFO.
//==============================================================
package wrp_pkg;

  // ==============================================================
  // Address map.
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hFF;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h01;
  localparam logic [7:0] EFFECT_ADDR = 8'h02;
  localparam int NUM_PAGES = 8;
  localparam int PAGE_BYTES = 256;
  localparam int MEM_BYTES = (NUM_PAGES - 1) * PAGE_BYTES;
  localparam logic [2:0] LAST_PAGE = 3'h7;

  // ==============================================================
  // Reset values and field positions.
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] EFFECT_RST = 8'h01;
  localparam int CTRL_GO_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int DESC_BYTES = 5;
  localparam int CHUNK_BYTES = 4;
  localparam int MODE_BIT = 7;

  // ==============================================================
  // Timing.
  localparam longint CLK_HZ = 40_000_000;
  localparam longint SAMPLE_HZ = 8_000;
  localparam int SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_HZ);
  localparam longint RAMP_STEP_MS = 32;
  // Samples in one ramp step; the gain moves 256 steps per ramp.
  localparam int RAMP_STEP_SAMPLES = int'(RAMP_STEP_MS * SAMPLE_HZ / 1000);
  localparam int GAIN_STEPS = 256;
  localparam int RAMP_SAMPLES_PER_STEP = RAMP_STEP_SAMPLES / GAIN_STEPS;
  // Frequency unit in microhertz and the matching 16-bit phase step.
  localparam longint FREQ_UNIT_UHZ = 7_812_500;
  localparam logic [15:0] PHASE_UNIT = 16'(65536 * FREQ_UNIT_UHZ / (SAMPLE_HZ * 1_000_000));

  // ==============================================================
  // Playback engine states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HDR = 5'h02,
    ST_DIR = 5'h04,
    ST_CHK = 5'h08,
    ST_SYN = 5'h10
  } wrp_state_t;

endpackage

// file: src/wrp_stream_if.sv
// Valid/ready byte stream carrier between the player and its FIFO.
`timescale 1ns/10ps
interface wrp_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: src/wrp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module wrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  wrp_stream_if.snk in_s,
  wrp_stream_if.src out_s
);
  import wrp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("wrp_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_width_chk
    $error("wrp_fifo: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic full_reg;
  logic nempty_reg;
  wire push = in_s.valid && !full_reg;
  wire pop = nempty_reg && out_s.ready;

  // Full and empty are registered so both handshakes start from a flop.
  assign in_s.ready = !full_reg;
  assign out_s.valid = nempty_reg;
  assign out_s.data = mem[rptr_reg];
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_reg] <= in_s.data;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
      nempty_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_reg + AW'(push);
      rptr_reg <= rptr_reg + AW'(pop);
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == (AW+1)'(DEPTH));
      nempty_reg <= (cnt_next != '0);
    end
  end
endmodule // wrp_fifo

// file: src/wrp_player.sv
// Paged waveform RAM with its register port and the direct/synthesis playback engine.
`timescale 1ns/10ps
module wrp_player #(
  parameter int SAMPLE_DIV = wrp_pkg::SAMPLE_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bus_start_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  output logic busy_o,
  output logic smp_valid_o,
  output logic [7:0] smp_data_o,
  input wire logic smp_ready_i
);
  import wrp_pkg::*;

  if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535) begin : g_div_chk
    $error("wrp_player: SAMPLE_DIV out of range");
  end

  // ==============================================================
  // Helper functions.

  // Quarter-wave sine, 16 points per quadrant, peak 126.
  function automatic logic signed [7:0] sine_lut(input logic [15:0] ph);
    logic [3:0] idx;
    logic [6:0] mag;
    idx = ph[14] ? ~ph[13:10] : ph[13:10];
    case (idx)
      4'h0: mag = 7'h00;
      4'h1: mag = 7'h0C;
      4'h2: mag = 7'h19;
      4'h3: mag = 7'h25;
      4'h4: mag = 7'h31;
      4'h5: mag = 7'h3C;
      4'h6: mag = 7'h47;
      4'h7: mag = 7'h51;
      4'h8: mag = 7'h5A;
      4'h9: mag = 7'h62;
      4'hA: mag = 7'h6A;
      4'hB: mag = 7'h70;
      4'hC: mag = 7'h75;
      4'hD: mag = 7'h7A;
      4'hE: mag = 7'h7D;
      default: mag = 7'h7E;
    endcase
    sine_lut = ph[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  // Scale a signed sample by k/255, approximated as k+1 over 256.
  function automatic logic signed [7:0] scale(input logic signed [7:0] s, input logic [7:0] k);
    logic signed [17:0] prod;
    prod = s * $signed({1'b0, 9'(k) + 9'h001});
    scale = (k == 8'h00) ? 8'sh00 : prod[15:8];
  endfunction

  // Map a page code and offset onto the linear storage index.
  function automatic logic [10:0] lin_addr(input logic [2:0] code, input logic [7:0] off);
    lin_addr = {code, off};
  endfunction

  // ==============================================================
  // Storage and register state.
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_reg;
  logic [7:0] ptr_reg;
  logic first_reg;
  logic go_reg;
  logic [7:0] effect_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic busy_reg;

  // Engine state.
  wrp_state_t st_reg;
  logic [2:0] idx_reg;
  logic [10:0] addr_reg;
  logic [10:0] start_reg;
  logic [10:0] stop_reg;
  logic synth_reg;
  logic [7:0] rep_reg;
  logic [7:0] rep_cnt_reg;
  logic [7:0] amp_reg;
  logic [7:0] freq_reg;
  logic [7:0] cyc_reg;
  logic [7:0] env_reg;
  logic [15:0] phase_reg;
  logic [7:0] cyc_cnt_reg;
  logic [7:0] gain_reg;
  logic [11:0] div_reg;
  logic down_reg;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic pend_reg;
  logic [7:0] smp_reg;

  // ==============================================================
  // Register port decode.
  wire ctl_space = (page_reg[2:0] == 3'h0);
  wire at_sel = (ptr_reg == PAGE_SEL_ADDR) && (ctl_space || first_reg);
  wire mem_hit = !ctl_space && !at_sel;
  wire [10:0] bus_lin = lin_addr(page_reg[2:0] - 3'h1, ptr_reg);
  wire wr_sel = bus_wr_i && at_sel;
  wire wr_ctrl = bus_wr_i && ctl_space && ptr_reg == CTRL_ADDR;
  wire wr_eff = bus_wr_i && ctl_space && ptr_reg == EFFECT_ADDR;
  wire wr_mem = bus_wr_i && mem_hit;
  wire wrap_wr = wr_mem && ptr_reg == 8'hFF && page_reg[2:0] != LAST_PAGE;

  // Read data mux; unused control offsets read as zero.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (at_sel) begin
      rd_mux = page_reg;
    end else if (mem_hit) begin
      rd_mux = mem[bus_lin];
    end else if (ptr_reg == STATUS_ADDR) begin
      rd_mux[STATUS_BUSY_BIT] = busy_reg;
    end else if (ptr_reg == CTRL_ADDR) begin
      rd_mux[CTRL_GO_BIT] = go_reg;
    end else if (ptr_reg == EFFECT_ADDR) begin
      rd_mux = effect_reg;
    end
  end

  // ==============================================================
  // Engine decode.
  wire [7:0] eng_byte = mem[addr_reg];
  wire [7:0] eff_k = (effect_reg == 8'h00) ? 8'h01 : effect_reg;
  wire [10:0] hdr_base = 11'h001 + 11'(DESC_BYTES) * (11'(eff_k) - 11'h001);
  wire [10:0] hdr_addr = hdr_base + 11'(idx_reg);
  wire take = tick_reg && !pend_reg;
  wire [3:0] up_n = env_reg[7:4];
  wire [3:0] dn_n = env_reg[3:0];
  wire [11:0] up_len = 12'(up_n) * 12'(RAMP_SAMPLES_PER_STEP);
  wire [11:0] dn_len = 12'(dn_n) * 12'(RAMP_SAMPLES_PER_STEP);
  wire [16:0] phase_sum = {1'b0, phase_reg} + 17'(freq_reg) * 17'(PHASE_UNIT);
  wire cyc_wrap = phase_sum[16];
  wire cyc_last = (cyc_reg == 8'h00) || (cyc_wrap && cyc_cnt_reg + 8'h01 >= cyc_reg);
  wire div_hit = (div_reg + 12'h001 >= (down_reg ? dn_len : up_len));
  wire dn_end = down_reg && take && div_hit && gain_reg <= 8'h01;
  wire cyc_end = !down_reg && take && cyc_last && dn_n == 4'h0;
  wire chunk_end = (st_reg == ST_SYN) && (dn_end || cyc_end);
  wire [11:0] chunk_last = {1'b0, addr_reg} - 12'h001;   // The fetch has already stepped past the chunk.
  wire dir_end = (st_reg == ST_DIR) && take && addr_reg == stop_reg;
  wire wave_end = dir_end || (chunk_end && chunk_last >= {1'b0, stop_reg});
  wire rep_done = (rep_reg != 8'h00) && (rep_cnt_reg + 8'h01 >= rep_reg);
  wire eng_done = wave_end && rep_done;
  wire signed [7:0] syn_smp = scale(scale(sine_lut(phase_reg), amp_reg), gain_reg);

  // ==============================================================
  // Register port: pointer, page selector and control registers.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      page_reg <= PAGE_SEL_RST;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      go_reg <= 1'b0;
      effect_reg <= EFFECT_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus_rd_i && !bus_start_i;
      busy_reg <= (st_reg != ST_IDLE);
      if (bus_start_i) begin
        ptr_reg <= bus_addr_i;
        first_reg <= 1'b1;
      end else if (bus_wr_i || bus_rd_i) begin
        ptr_reg <= ptr_reg + 8'h01;
        first_reg <= 1'b0;
      end
      if (bus_rd_i && !bus_start_i) begin
        rdata_reg <= rd_mux;
      end
      if (wr_sel) begin
        page_reg <= bus_wdata_i;
      end else if (wrap_wr) begin
        page_reg <= page_reg + 8'h01;
      end
      // A software write in the ending cycle wins over the hardware clear.
      if (wr_ctrl) begin
        go_reg <= bus_wdata_i[CTRL_GO_BIT];
      end else if (eng_done) begin
        go_reg <= 1'b0;
      end
      if (wr_eff) begin
        effect_reg <= bus_wdata_i;
      end
    end
  end

  // Waveform storage is deliberately outside reset so content survives it.
  always_ff @(posedge clk_i) begin
    if (wr_mem) begin
      mem[bus_lin] <= bus_wdata_i;
    end
  end

  // ==============================================================
  // Sample-rate enable: one pulse every SAMPLE_DIV clocks.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 16'(SAMPLE_DIV - 1));
      tick_cnt_reg <= (tick_cnt_reg == 16'(SAMPLE_DIV - 1)) ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // ==============================================================
  // Stream towards the FIFO. A sample waits here when the FIFO is full,
  // which holds back further ticks and so stalls playback.
  wrp_stream_if #(.WIDTH(8)) fin_if ();
  wrp_stream_if #(.WIDTH(8)) fout_if ();

  assign fin_if.valid = pend_reg;
  assign fin_if.data = smp_reg;
  assign fout_if.ready = smp_ready_i;
  assign smp_valid_o = fout_if.valid;
  assign smp_data_o = fout_if.data;

  wrp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_s(fin_if),
    .out_s(fout_if)
  );

  // ==============================================================
  // Playback engine.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      addr_reg <= 11'h000;
      start_reg <= 11'h000;
      stop_reg <= 11'h000;
      synth_reg <= 1'b0;
      rep_reg <= 8'h00;
      rep_cnt_reg <= 8'h00;
      amp_reg <= 8'h00;
      freq_reg <= 8'h00;
      cyc_reg <= 8'h00;
      env_reg <= 8'h00;
      phase_reg <= 16'h0000;
      cyc_cnt_reg <= 8'h00;
      gain_reg <= 8'h00;
      div_reg <= 12'h000;
      down_reg <= 1'b0;
      pend_reg <= 1'b0;
      smp_reg <= 8'h00;
    end else begin
      if (pend_reg && fin_if.ready) begin
        pend_reg <= 1'b0;
      end
      case (st_reg)
        ST_IDLE: begin
          idx_reg <= 3'h0;
          if (go_reg) begin
            st_reg <= ST_HDR;
          end
        end
        ST_HDR: begin
          // One descriptor byte per clock, in stored order.
          idx_reg <= idx_reg + 3'h1;
          case (idx_reg)
            3'h0: begin
              synth_reg <= mem[hdr_addr][MODE_BIT];
              start_reg[10:8] <= mem[hdr_addr][2:0];
            end
            3'h1: start_reg[7:0] <= mem[hdr_addr];
            3'h2: stop_reg[10:8] <= mem[hdr_addr][2:0];
            3'h3: stop_reg[7:0] <= mem[hdr_addr];
            default: begin
              rep_reg <= mem[hdr_addr];
              rep_cnt_reg <= 8'h00;
              addr_reg <= start_reg;
              idx_reg <= 3'h0;
              st_reg <= synth_reg ? ST_CHK : ST_DIR;
            end
          endcase
        end
        ST_DIR: begin
          if (take) begin
            smp_reg <= eng_byte;
            pend_reg <= 1'b1;
            addr_reg <= addr_reg + 11'h001;
          end
        end
        ST_CHK: begin
          // Chunk bytes arrive in the order amplitude, frequency, cycles, envelope.
          idx_reg <= idx_reg + 3'h1;
          addr_reg <= addr_reg + 11'h001;
          case (idx_reg)
            3'h0: amp_reg <= eng_byte;
            3'h1: freq_reg <= eng_byte;
            3'h2: cyc_reg <= eng_byte;
            default: begin
              env_reg <= eng_byte;
              phase_reg <= 16'h0000;
              cyc_cnt_reg <= 8'h00;
              div_reg <= 12'h000;
              down_reg <= 1'b0;
              gain_reg <= (eng_byte[7:4] == 4'h0) ? 8'hFF : 8'h00;
              idx_reg <= 3'h0;
              st_reg <= ST_SYN;
            end
          endcase
        end
        ST_SYN: begin
          if (take) begin
            smp_reg <= syn_smp;
            pend_reg <= 1'b1;
            phase_reg <= phase_sum[15:0];
            if (cyc_wrap) begin
              cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
            end
            if (!down_reg && cyc_last) begin
              down_reg <= 1'b1;
              div_reg <= 12'h000;
            end else if (down_reg || (up_n != 4'h0 && gain_reg != 8'hFF)) begin
              // Gain steps once per ramp length over 256 samples.
              div_reg <= div_hit ? 12'h000 : div_reg + 12'h001;
              if (div_hit) begin
                gain_reg <= down_reg ? gain_reg - 8'h01 : gain_reg + 8'h01;
              end
            end
          end
          if (chunk_end) begin
            st_reg <= ST_CHK;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
      // Waveform end: repeat, or finish; dropping the trigger aborts at once.
      if (wave_end) begin
        if (rep_done) begin
          st_reg <= ST_IDLE;
        end else begin
          rep_cnt_reg <= (rep_reg == 8'h00) ? 8'h00 : rep_cnt_reg + 8'h01;
          addr_reg <= start_reg;
          st_reg <= synth_reg ? ST_CHK : ST_DIR;
        end
      end
      if (!go_reg && st_reg != ST_IDLE) begin
        st_reg <= ST_IDLE;
      end
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign bus_rvalid_o = rvalid_reg;
  assign busy_o = busy_reg;
endmodule // wrp_player

// file: verification/wrp_player_checker.sv
// Concurrent checks on the ports of the waveform RAM player.
`timescale 1ns/10ps
module wrp_player_checker #(
  parameter int SAMPLE_DIV = 10,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bus_start_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic bus_rvalid_o,
  input wire logic busy_o,
  input wire logic smp_valid_o,
  input wire logic [7:0] smp_data_o,
  input wire logic smp_ready_i
);
  // ==============================================================
  // Properties, all in the core clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_rvalid_cause: assert property (bus_rd_i && !bus_start_i |=> bus_rvalid_o)
    else $error("read byte gave no valid pulse");
  a_rvalid_only: assert property (bus_rvalid_o |-> $past(bus_rd_i) && !$past(bus_start_i))
    else $error("valid pulse without a read");
  a_rdata_hold: assert property (!bus_rvalid_o |-> $stable(bus_rdata_o))
    else $error("read data moved without a read");
  a_head_stands: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
    else $error("sample changed while the sink stalled");
  a_idle_quiet: assert property ((!busy_o && !smp_valid_o) [*3] |=> !smp_valid_o)
    else $error("sample produced while idle");
  a_hdr_quiet: assert property ($rose(busy_o) && !smp_valid_o |-> !smp_valid_o [*4])
    else $error("sample before the header was fetched");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*5])
    else $error("engine left before reading a descriptor");
  // Reset quiets the outputs; stored bytes are checked by the bench.
  a_reset_clear: assert property (disable iff (1'b0) srst_i |=> !bus_rvalid_o && !busy_o && !smp_valid_o)
    else $error("outputs active after reset");
  c_read: cover property (bus_rvalid_o);
  c_stall: cover property (smp_valid_o && !smp_ready_i);
  c_play: cover property ($rose(busy_o));
endmodule // wrp_player_checker

bind wrp_player wrp_player_checker #(.SAMPLE_DIV(SAMPLE_DIV), .FIFO_DEPTH(FIFO_DEPTH)) wrp_player_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .bus_start_i(bus_start_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
  .bus_wdata_i(bus_wdata_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
  .busy_o(busy_o), .smp_valid_o(smp_valid_o), .smp_data_o(smp_data_o), .smp_ready_i(smp_ready_i));

// file: verification/wrp_sample_sink.sv
// Sample sink standing at the far end of the player's output stream.
`timescale 1ns/10ps
module wrp_sample_sink (
  input wire logic clk_i,
  input wire logic smp_valid_i,
  input wire logic [7:0] smp_data_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic smp_ready_o = 1'b0,
  output int count_o = 0
);
  logic [7:0] got [0:511];
  int stamp [0:511];
  int cyc = 0;
  logic [1:0] phase_reg = 2'h0;
  // Ready moves at the falling edge, away from the design's sampling edge; slow mode accepts one cycle in four.
  always @(negedge clk_i) begin
    phase_reg <= phase_reg + 2'h1;
    smp_ready_o <= !stall_i && (!slow_i || phase_reg == 2'h3);
  end
  // A sample is taken at the rising edge where the design sees valid and ready together.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (smp_valid_i && smp_ready_o) begin
      got[count_o[8:0]] <= smp_data_i;
      stamp[count_o[8:0]] <= cyc;
      count_o <= count_o + 1;
    end
  end
endmodule // wrp_sample_sink

// file: verification/wrp_player_tb.sv
// Self-checking bench for the waveform RAM player.
`timescale 1ns/10ps
module wrp_player_tb;
  import wrp_pkg::*;
  localparam int DIV = 10;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic bus_start_i = 1'b0;
  logic [7:0] bus_addr_i = 8'h00;
  logic bus_wr_i = 1'b0;
  logic [7:0] bus_wdata_i = 8'h00;
  logic bus_rd_i = 1'b0;
  logic [7:0] bus_rdata_o;
  logic bus_rvalid_o;
  logic busy_o;
  logic smp_valid_o;
  logic [7:0] smp_data_o;
  logic smp_ready_i;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int got_n;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int base = 0;
  int t;

  wrp_player #(.SAMPLE_DIV(DIV), .FIFO_DEPTH(16)) wrp_player_inst (
    .clk_i(clk_i), .srst_i(srst_i), .bus_start_i(bus_start_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
    .bus_wdata_i(bus_wdata_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
    .busy_o(busy_o), .smp_valid_o(smp_valid_o), .smp_data_o(smp_data_o), .smp_ready_i(smp_ready_i));
  wrp_sample_sink wrp_sample_sink_inst (.clk_i(clk_i), .smp_valid_i(smp_valid_o), .smp_data_i(smp_data_o),
    .stall_i(stall), .slow_i(slow), .smp_ready_o(smp_ready_i), .count_o(got_n));

  // ==============================================================
  // Clock, and a ceiling well above the under two thousand cycles the run needs.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  // ==============================================================
  // Bus tasks; every input changes at the falling edge only.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic start(input logic [7:0] a);
    @(negedge clk_i);
    bus_start_i = 1'b1;
    bus_addr_i = a;
    @(negedge clk_i);
    bus_start_i = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    start(a);
    foreach (d[i]) begin
      bus_wr_i = 1'b1;
      bus_wdata_i = d[i];
      @(negedge clk_i);
    end
    bus_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    start(a);
    bus_rd_i = 1'b1;
    @(negedge clk_i);
    bus_rd_i = 1'b0;
    check({what, " valid"}, 8'h01, {7'h00, bus_rvalid_o});
    check(what, exp, bus_rdata_o);
  endtask
  task automatic page(input logic [7:0] p);
    wr(PAGE_SEL_ADDR, '{p});
  endtask
  function automatic logic [7:0] smp(input int i);
    return wrp_sample_sink_inst.got[base + i];
  endfunction
  function automatic int gap(input int i);
    return wrp_sample_sink_inst.stamp[base + i] - wrp_sample_sink_inst.stamp[base + i - 1];
  endfunction
  // Starts an effect and, for a finite one, waits until all samples arrived and the engine is idle.
  task automatic play(input logic [7:0] id, input int n);
    base = got_n;
    page(8'h00);
    wr(EFFECT_ADDR, '{id});
    wr(CTRL_ADDR, '{8'h01});
    t = 0;
    while (n > 0 && (got_n < base + n || busy_o) && t < 5000) begin
      @(negedge clk_i);
      t++;
    end
    repeat (20) @(negedge clk_i);
    if (n > 0) check("count", 8'(n), 8'(got_n - base));
  endtask
  task automatic expect_run(input logic [7:0] e[$]);
    foreach (e[i]) check("sample", e[i], smp(i));
    rd(CTRL_ADDR, 8'h00, "go");
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==============================================================
  // Main sequence.
  initial begin
    repeat (4) @(negedge clk_i);
    srst_i = 1'b0;
    rd(PAGE_SEL_ADDR, PAGE_SEL_RST, "page");
    rd(EFFECT_ADDR, EFFECT_RST, "effect");
    rd(8'h40, 8'h00, "unmapped");
    page(8'h01);
    rd(PAGE_SEL_ADDR, 8'h01, "page rw");
    wr(8'h00, '{8'h1A, 8'h00, 8'h20, 8'h00, 8'h22, 8'h02, 8'h00, 8'hFE, 8'h01, 8'h01, 8'h01,
      8'h82, 8'h00, 8'h02, 8'h07, 8'h01, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00,
      8'h82, 8'h08, 8'h02, 8'h0B, 8'h01});
    wr(8'h20, '{8'h80, 8'hFF, 8'h00});
    wr(8'hFE, '{8'h11, 8'h22, 8'h33, 8'h44});
    rd(PAGE_SEL_ADDR, 8'h02, "page bump");
    rd(8'h01, 8'h44, "next page");
    page(8'h03);
    wr(8'h00, '{8'h00, 8'h40, 8'h01, 8'h00, 8'hFF, 8'h40, 8'h02, 8'h00,
      8'hFF, 8'h40, 8'h02, 8'h10});
    // A reset in mid-run must leave the stored bytes alone.
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    page(8'h01);
    rd(8'h21, 8'hFF, "retained");
    slow = 1'b1;
    play(8'h01, 6);
    expect_run('{8'h80, 8'hFF, 8'h00, 8'h80, 8'hFF, 8'h00});
    slow = 1'b0;
    play(8'h02, 4);
    expect_run('{8'h11, 8'h22, 8'h33, 8'h44});
    for (int i = 1; i < 4; i++) check("gap", 8'(DIV), 8'(gap(i)));
    play(8'h03, 48);
    for (int i = 0; i < 17; i++) check("silence", 8'h00, smp(i));
    check("peak", 8'h01, {7'h00, $signed(smp(20)) > $signed(8'h70)});
    check("trough", 8'h01, {7'h00, $signed(smp(28)) < $signed(8'h90)});
    // Same two full-scale cycles, but the ramp-up starts the gain from zero inside the duration.
    play(8'h05, 32);
    check("ramp", 8'h01, {7'h00, smp(4) < 8'h10});
    // The stalled sink lets the FIFO fill while the endless loop runs.
    stall = 1'b1;
    play(8'h04, 0);
    repeat (400) @(negedge clk_i);
    check("full", 8'h01, {7'h00, smp_valid_o});
    stall = 1'b0;
    repeat (60) @(negedge clk_i);
    check("looping", 8'h01, {7'h00, busy_o});
    rd(STATUS_ADDR, 8'h01, "status");
    wr(CTRL_ADDR, '{8'h00});
    repeat (60) @(negedge clk_i);
    check("stopped", 8'h00, {7'h00, busy_o | smp_valid_o});
    check("loop fill", 8'h01, {7'h00, got_n - base > 20});
    for (int i = 0; i < 20; i++) check("loop", 8'h80, smp(i));
    complete_run();
  end
endmodule // wrp_player_tb
